// File: shared/oobtx_pkg.sv
// Constants for the out-of-band flow-control transmitter.
// Assumes one 250 MHz clock that also serves as the link reference clock.
`default_nettype none
package oobtx_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int MAX_CAL      = 256;
    localparam int SLICE_BITS   = 64;
    localparam int UPD_W        = (MAX_CAL + SLICE_BITS - 1) / SLICE_BITS;
    localparam int LANES        = 12;
    localparam int IDX_W        = 9;
    // Link clock is the reference divided by this
    localparam int LINK_DIV     = 2;
    // ------------------------------------------------------------
    // Register map (byte addresses) and reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_CTRL    = 4'h0;
    localparam logic [3:0]  ADDR_STATUS  = 4'h4;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          STAT_SEND_BIT = 0;
    localparam int          STAT_CNT_LSB = 8;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_LATCH = 3'h2,
        ST_SEND  = 3'h4
    } oobtx_state_t;
endpackage
`default_nettype wire

// File: hdl/oobtx_top.sv
// Out-of-band flow-control transmitter: latches permission and health bits
// and shifts them out on a forwarded clock, serial line and frame sync.
// Assumes user inputs synchronous to mclk; mclk doubles as link reference.
// Operation
// - With status send enabled, health inputs are sampled and sent.
// - With status send disabled, health inputs are ignored and no status goes out.
// - Update bit 0 captures channels 63:0 and health bits at the end of that cycle.
// - Update bit n captures the nth 64-channel slice at the end of that cycle.
// - The update bus is driven synchronously to the user clock.
// - The link clock is the reference clock divided by two.
// - The link clock is forwarded with data and sync for the peer to sample.
// - Latched permission and status bits are shifted onto the serial line.
// - Frame sync marks the first bit of each transmitted sequence.
// - Reset is synchronised internally and holds every circuit except the AXI ready outputs while asserted.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module oobtx_top
    import oobtx_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               rstn,
    input  wire logic [MAX_CAL-1:0] channel_permission_bits,
    input  wire logic [7:0]         calendar_length_less_one,
    input  wire logic [3:0]         lane_count_less_one,
    input  wire logic               status_send_enable,
    input  wire logic               intf_health,
    input  wire logic [LANES-1:0]   lane_health,
    output logic [UPD_W-1:0]        latch_strobe,
    output logic                    oob_link_clock,
    output logic                    oob_link_serial_line,
    output logic                    oob_link_frame_sync,
    input  wire logic [3:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [3:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);
    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic               rs_meta_r;
    logic               rst_ok_r;
    logic [MAX_CAL-1:0] fc_lat_r;
    logic [LANES-1:0]   lane_lat_r;
    logic               intf_lat_r;
    logic               sten_lat_r;
    logic               phase_r;
    logic [IDX_W-1:0]   idx_r;
    logic               ser_r;
    logic               sync_r;
    logic [7:0]         frames_r;
    logic [31:0]        ctrl_r;
    oobtx_state_t       state_r;
    oobtx_state_t       state_nxt;

    // Assert at once, release after two edges so no flop leaves reset early
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rs_meta_r <= 1'b0;
            rst_ok_r  <= 1'b0;
        end else begin
            rs_meta_r <= 1'b1;
            rst_ok_r  <= rs_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Frame layout helpers
    // ------------------------------------------------------------
    // Status header length: interface bit plus one bit per lane
    function automatic logic [IDX_W-1:0] hdr_len(input logic en, input logic [3:0] lanes);
        hdr_len = en ? IDX_W'(lanes) + IDX_W'(2) : '0;
    endfunction

    // Bit of the frame at index i, from the latched copy only
    function automatic logic bit_at(input logic [IDX_W-1:0] i, input logic [IDX_W-1:0] h);
        logic [IDX_W-1:0] k;
        k = i - h;
        if (i < h)
            bit_at = (i == '0) ? intf_lat_r : lane_lat_r[4'(i - IDX_W'(1))];
        else
            bit_at = fc_lat_r[k[7:0]];
    endfunction
    wire logic [IDX_W-1:0] hdr_w   = hdr_len(sten_lat_r, lane_count_less_one);
    wire logic [IDX_W-1:0] last_w  = hdr_w + IDX_W'(calendar_length_less_one);
    wire logic             enab_w  = ctrl_r[CTRL_EN_BIT];
    wire logic             step_w  = phase_r; // end of a link bit period
    wire logic             upd_w   = (state_r == ST_LATCH) && !phase_r;

    // ------------------------------------------------------------
    // Update strobe decode
    // ------------------------------------------------------------
    // One bit per slice up to the configured calendar, others stay low
    for (genvar g = 0; g < UPD_W; g++) begin : g_upd
        assign latch_strobe[g] = upd_w &&
            (2'(g) <= calendar_length_less_one[7:6]);
    end

    // ------------------------------------------------------------
    // Latches for the outgoing frame
    // ------------------------------------------------------------
    // Captured at the end of the strobe cycle, so data may change after it
    always_ff @(posedge mclk) begin
        if (!rst_ok_r) begin
            fc_lat_r   <= '0;
            lane_lat_r <= '0;
            intf_lat_r <= 1'b0;
            sten_lat_r <= 1'b0;
        end else begin
            for (int s = 0; s < UPD_W; s++) begin
                if (latch_strobe[s])
                    fc_lat_r[s*SLICE_BITS +: SLICE_BITS] <=
                        channel_permission_bits[s*SLICE_BITS +: SLICE_BITS];
            end
            if (latch_strobe[0]) begin
                sten_lat_r <= status_send_enable;
                intf_lat_r <= status_send_enable & intf_health;
                lane_lat_r <= status_send_enable ? lane_health : '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // States move only at the end of a link bit so every bit is two mclk long
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:  state_nxt = (enab_w && step_w) ? ST_LATCH : ST_IDLE;
            ST_LATCH: state_nxt = step_w ? ST_SEND : ST_LATCH;
            ST_SEND: begin
                if (step_w && idx_r == last_w)
                    state_nxt = enab_w ? ST_LATCH : ST_IDLE;
            end
            default:  state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_ok_r)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // ------------------------------------------------------------
    // Link clock and serialiser
    // ------------------------------------------------------------
    // Data and sync change as the forwarded clock falls; peer samples on rise
    always_ff @(posedge mclk) begin
        if (!rst_ok_r) begin
            phase_r  <= 1'b0;
            idx_r    <= '0;
            ser_r    <= 1'b0;
            sync_r   <= 1'b0;
            frames_r <= '0;
        end else begin
            phase_r <= ~phase_r;
            if (step_w) begin
                if (state_nxt == ST_SEND) begin
                    if (state_r == ST_LATCH) begin
                        idx_r  <= '0;
                        ser_r  <= bit_at('0, hdr_w);
                        sync_r <= 1'b1;
                    end else begin
                        idx_r  <= idx_r + IDX_W'(1);
                        ser_r  <= bit_at(idx_r + IDX_W'(1), hdr_w);
                        sync_r <= 1'b0;
                    end
                end else begin
                    ser_r  <= 1'b0;
                    sync_r <= 1'b0;
                end
                if (state_r == ST_SEND && state_nxt != ST_SEND)
                    frames_r <= frames_r + 8'h01;
            end
        end
    end

    // Forwarded clock is the divider flop itself, aligned with data
    assign oob_link_clock       = phase_r;
    assign oob_link_serial_line = ser_r;
    assign oob_link_frame_sync  = sync_r;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // Write taken only with address and data together; one at a time
    wire logic wr_go   = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire logic wr_ctrl = (s_axi_awaddr == ADDR_CTRL);
    wire logic rd_go   = s_axi_arvalid && !s_axi_rvalid;
    wire logic rd_ok   = (s_axi_araddr == ADDR_CTRL) || (s_axi_araddr == ADDR_STATUS);
    wire logic [31:0] stat_w = (32'(frames_r) << STAT_CNT_LSB) | (32'(state_r == ST_SEND) << STAT_SEND_BIT);
    wire logic [31:0] rd_w = (s_axi_araddr == ADDR_CTRL) ? ctrl_r :
                             (s_axi_araddr == ADDR_STATUS) ? stat_w : 32'h0000_0000;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;

    always_ff @(posedge mclk) begin
        if (!rst_ok_r) begin
            ctrl_r       <= CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= '0;
        end else begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_ctrl || s_axi_awaddr == ADDR_STATUS) ? RESP_OKAY
                                                                           : RESP_SLVERR;
                if (wr_ctrl && s_axi_wstrb[0])
                    ctrl_r[7:0] <= s_axi_wdata[7:0];
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_w;
                s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_sync_bit;
        oob_link_frame_sync [*2] ##1 !oob_link_frame_sync;
    endsequence

    property p_div;
        @(posedge mclk) disable iff (!rst_ok_r)
        $past(rst_ok_r) |-> oob_link_clock != $past(oob_link_clock);
    endproperty
    a_div: assert property (p_div) else $error("link clock not half rate");
    property p_slice0;
        @(posedge mclk) disable iff (!rst_ok_r)
        latch_strobe[0] |=> fc_lat_r[63:0] == $past(channel_permission_bits[63:0]);
    endproperty
    a_slice0: assert property (p_slice0) else $error("slice 0 not captured");
    property p_slice1;
        @(posedge mclk) disable iff (!rst_ok_r)
        latch_strobe[1] |=> fc_lat_r[127:64] == $past(channel_permission_bits[127:64]);
    endproperty
    a_slice1: assert property (p_slice1) else $error("slice 1 not captured");
    property p_health;
        @(posedge mclk) disable iff (!rst_ok_r)
        latch_strobe[0] && status_send_enable |=> intf_lat_r == $past(intf_health);
    endproperty
    a_health: assert property (p_health) else $error("health not sampled");
    property p_nostat;
        @(posedge mclk) disable iff (!rst_ok_r)
        $rose(oob_link_frame_sync) && !sten_lat_r |-> oob_link_serial_line == fc_lat_r[0];
    endproperty
    a_nostat: assert property (p_nostat) else $error("status sent while off");
    property p_sync;
        @(posedge mclk) disable iff (!rst_ok_r)
        $rose(oob_link_frame_sync) |-> s_sync_bit;
    endproperty
    a_sync: assert property (p_sync) else $error("sync not one bit long");
    property p_strobe;
        @(posedge mclk) disable iff (!rst_ok_r)
        (latch_strobe != '0) |-> latch_strobe[0] ##1 (latch_strobe == '0);
    endproperty
    a_strobe: assert property (p_strobe) else $error("bad update strobe");
    property p_edge;
        @(posedge mclk) disable iff (!rst_ok_r)
        $changed(oob_link_serial_line) |-> !oob_link_clock;
    endproperty
    a_edge: assert property (p_edge) else $error("data moved on rising edge");
    property p_rst;
        @(posedge mclk)
        !rst_ok_r |=> !oob_link_frame_sync && latch_strobe == '0;
    endproperty
    a_rst: assert property (p_rst) else $error("activity during reset");
endmodule
`default_nettype wire

// File: tb/oobtx_peer_rx.sv
// Peer receiver model for the out-of-band flow-control link.
// Assumes data and sync change while the forwarded clock goes low.
`timescale 1ns/1ps
`default_nettype none
module oobtx_peer_rx (
    input  wire logic         link_clk,
    input  wire logic         serial,
    input  wire logic         sync,
    output logic [299:0]      last_bits,
    output int                last_len,
    output int                frames
);
    logic [299:0] cur;
    int           idx;

    // ------------------------------------------------------------
    // Frame capture
    // ------------------------------------------------------------
    initial begin
        cur = '0;
        idx = 0;
        last_bits = '0;
        last_len = 0;
        frames = 0;
    end

    // Sample on the rising edge of the forwarded clock
    // Sync opens a frame; the previous one closes less its latch bit
    always @(posedge link_clk) begin
        if (sync) begin
            if (idx > 0) begin
                last_bits = cur;
                last_len = idx - 1;
                frames = frames + 1;
            end
            cur = '0;
            idx = 0;
        end
        if (idx < 300) begin
            cur[idx] = serial;
        end
        idx = idx + 1;
    end
endmodule
`default_nettype wire

// File: tb/oobtx_top_tb.sv
// Testbench for the flow-control transmitter: frames, link clock, registers.
// Assumes the peer model and a single 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module oobtx_top_tb;
    import oobtx_pkg::*;
    `define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
        $display("ERROR %s expected %h seen %h", nm, ex, got); end end
    logic mclk = 1'b0, rstn = 1'b0, sse = 1'b0, ih = 1'b1;
    logic [MAX_CAL-1:0] chb = '0;
    logic [LANES-1:0] lh = '0;
    logic [UPD_W-1:0] stb;
    logic lclk, ser, syn, awr, wr_, bv, arr, rv;
    logic [3:0] awa = 4'h0, ara = 4'h0;
    logic [31:0] wd = 32'h0, rd_d, rdat;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [1:0] bresp, rresp, rsp;
    logic [299:0] pbits;
    int plen, pfr, err_total = 0, checks_done = 0;

    always #2 mclk = ~mclk;

    // Small calendar and two lanes keep frames short
    oobtx_top dut (.mclk(mclk), .rstn(rstn), .channel_permission_bits(chb),
        .calendar_length_less_one(8'h7F), .lane_count_less_one(4'h1),
        .status_send_enable(sse), .intf_health(ih), .lane_health(lh),
        .latch_strobe(stb), .oob_link_clock(lclk), .oob_link_serial_line(ser),
        .oob_link_frame_sync(syn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
    oobtx_peer_rx peer (.link_clk(lclk), .serial(ser), .sync(syn),
        .last_bits(pbits), .last_len(plen), .frames(pfr));

    // ------------------------------------------------------------
    // Bus and wait helpers
    // ------------------------------------------------------------
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do @(negedge mclk); while (!(awr === 1'b1 && wr_ === 1'b1));
        @(posedge mclk);
        awv <= 1'b0;
        wv <= 1'b0;
        do @(negedge mclk); while (bv !== 1'b1);
        r = bresp;
        @(posedge mclk);
        br <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(negedge mclk); while (arr !== 1'b1);
        @(posedge mclk);
        arv <= 1'b0;
        do @(negedge mclk); while (rv !== 1'b1);
        d = rdat;
        r = rresp;
        @(posedge mclk);
        rr <= 1'b0;
    endtask

    // Frames close only at the next sync, so a latched frame needs two
    task automatic wait_frames(input int n);
        int f0;
        f0 = pfr;
        while (pfr < f0 + n) @(posedge mclk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_link_clock;
        logic prev;
        @(negedge mclk);
        prev = lclk;
        repeat (6) begin
            @(negedge mclk);
            `CHK("link_clock", ~prev, lclk)
            prev = lclk;
        end
        $display("test_link_clock done");
    endtask

    // Inputs are scrambled right after the strobe: the frame must hold old values
    task automatic test_frame(input logic en, input logic [255:0] c, input logic h,
                              input logic [11:0] l);
        logic [299:0] ex;
        int n;
        @(posedge mclk);
        sse <= en;
        ih <= h;
        lh <= l;
        chb <= c;
        wait_frames(1);
        do @(negedge mclk); while (stb[0] !== 1'b1);
        `CHK("strobe", 4'h3, stb)
        @(posedge mclk);
        chb <= ~c;
        ih <= ~h;
        lh <= ~l;
        @(negedge mclk);
        `CHK("strobe_pulse", 4'h0, stb)
        wait_frames(2);
        ex = '0;
        n = en ? 3 : 0;
        ex[0] = en & h;
        ex[1] = en & l[0];
        ex[2] = en & l[1];
        if (!en) ex[2:0] = c[2:0];
        for (int i = 0; i < 128; i++) ex[n+i] = c[i];
        `CHK("frame_len", n + 128, plen)
        `CHK("frame_bits", ex, pbits)
        chb <= c;
        $display("test_frame en=%0d done", en);
    endtask

    task automatic test_regs;
        int bad;
        logic [31:0] st0;
        axi_rd(ADDR_CTRL, rd_d, rsp);
        `CHK("ctrl_reset", CTRL_RESET, rd_d)
        axi_wr(ADDR_CTRL, 32'h1234_56A5, rsp);
        axi_rd(ADDR_CTRL, rd_d, rsp);
        `CHK("ctrl_rw", 32'h0000_00A5, rd_d)
        axi_wr(4'h8, 32'hFFFF_FFFF, rsp);
        `CHK("unmapped_wr", RESP_SLVERR, rsp)
        axi_rd(4'h8, rd_d, rsp);
        `CHK("unmapped_rd", RESP_SLVERR, rsp)
        axi_wr(ADDR_STATUS, 32'h0, rsp);
        `CHK("status_wr", RESP_OKAY, rsp)
        axi_wr(ADDR_CTRL, 32'h0, rsp);
        repeat (600) @(posedge mclk);
        bad = 0;
        repeat (40) @(negedge mclk) bad += (syn !== 1'b0 || ser !== 1'b0);
        `CHK("link_idle", 0, bad)
        axi_rd(ADDR_STATUS, rd_d, rsp);
        `CHK("status_idle", 24'h0, {rd_d[31:16], rd_d[7:0]})
        `CHK("status_rd", RESP_OKAY, rsp)
        axi_wr(ADDR_CTRL, 32'h1, rsp);
        `CHK("ctrl_wr", RESP_OKAY, rsp)
        do @(negedge mclk); while (syn !== 1'b1);
        axi_rd(ADDR_STATUS, st0, rsp);
        `CHK("status_busy", 1'b1, st0[0])
        wait_frames(1);
        axi_rd(ADDR_STATUS, rd_d, rsp);
        `CHK("status_frames", st0[15:8] + 8'h01, rd_d[15:8])
        $display("test_regs done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Watchdog sized well above the few thousand cycles the tests need
    initial begin
        repeat (30000) @(posedge mclk);
        err_total++;
        results();
    end

    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        test_link_clock();
        test_frame(1'b1, {128'h0, 128'hC3A5_0F1E_8001_7FFE_DEAD_BEEF_0123_4567}, 1'b1, 12'h002);
        test_frame(1'b0, {128'h0, 128'h5A5A_F00F_1234_0001_8000_FFFF_0000_C001}, 1'b0, 12'h555);
        test_regs();
        results();
    end
endmodule
`default_nettype wire
